// ==== verilog/mon_pkg.sv ====
package mon_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the register port.
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG   = 8'h40; // Monitor configuration.
    localparam logic [7:0] ADDR_STATUS1  = 8'h41; // First event status, clears on read.
    localparam logic [7:0] ADDR_STATUS2  = 8'h42; // Second event status, clears on read.
    localparam logic [7:0] ADDR_MMASK1   = 8'h43; // First management interrupt mask.
    localparam logic [7:0] ADDR_MMASK2   = 8'h44; // Second management interrupt mask.
    localparam logic [7:0] ADDR_HMASK1   = 8'h45; // First host interrupt mask.
    localparam logic [7:0] ADDR_HMASK2   = 8'h46; // Second host interrupt mask.

    // ------------------------------------------------------------------
    // Power-on values.
    // ------------------------------------------------------------------
    localparam logic [7:0] CONFIG_RESET  = 8'h08; // Stopped, interrupt clearing active.
    localparam logic [7:0] STATUS_RESET  = 8'h00; // No events latched.
    localparam logic [7:0] MMASK_RESET   = 8'h00; // Nothing masked.
    localparam logic [7:0] HMASK1_RESET  = 8'h00; // Nothing masked.
    localparam logic [7:0] HMASK2_RESET  = 8'h40; // External input event masked.
    localparam logic [7:0] READ_UNMAPPED = 8'h00; // Answer to an unmapped offset.

    // ------------------------------------------------------------------
    // Configuration field positions.
    // ------------------------------------------------------------------
    localparam int CFG_START       = 0; // Run monitoring.
    localparam int CFG_MGMT_EN     = 1; // Management interrupt output enable.
    localparam int CFG_HOST_EN     = 2; // Host interrupt output enable.
    localparam int CFG_INT_CLEAR   = 3; // Hold outputs off and halt monitoring.
    localparam int CFG_RESET_PULSE = 4; // Request a reset pulse, self clearing.
    localparam int CFG_NMI_SEL     = 5; // One: non-maskable flavour, zero: request.
    localparam int CFG_BYPASS      = 6; // Drive the bypass pin low.
    localparam int CFG_RESTORE     = 7; // Restore defaults, reads as zero.

    // ------------------------------------------------------------------
    // Other field positions.
    // ------------------------------------------------------------------
    localparam int MMASK2_RESET_EN = 7; // Allows the reset pulse.
    localparam logic [4:0] POST_LAST_ADDR = 5'h1f; // 32nd storage location.

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int CLK_FREQ_HZ       = 50_000_000; // Core clock rate.
    localparam int RESET_PULSE_MS    = 20;         // Least reset pulse width.
    localparam int RESET_PULSE_CYCLES =
        (CLK_FREQ_HZ / 1000 * RESET_PULSE_MS) < 1 ? 1 :
        (CLK_FREQ_HZ / 1000 * RESET_PULSE_MS);     // Exact, so no rounding needed.

endpackage : mon_pkg

// ==== verilog/pulse_timer.sv ====
// ----------------------------------------------------------------------
// Down counter that holds busy for a fixed number of enabled cycles.
// ----------------------------------------------------------------------
module pulse_timer #(
    parameter int CYCLES = 1000000 // Pulse length in clock cycles.
) (
    input  wire logic clk,   // Core clock.
    input  wire logic rst_n, // Asynchronous reset, active low.
    input  wire logic ce,    // Clock enable, freezes the counter when low.
    input  wire logic start, // Begin a pulse; ignored while busy.
    input  wire logic abort, // Stop at once without a done pulse.
    output logic      busy,  // High for exactly CYCLES enabled cycles.
    output logic      done   // One-cycle pulse as busy falls.
);

    localparam int CW = $clog2(CYCLES + 1);               // Counter width.
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);         // Load value.
    localparam logic [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};

    logic [CW-1:0] count_reg; // Remaining cycles of the pulse.
    logic [CW-1:0] count_next;
    logic          done_reg;  // Registered end marker.
    logic          done_next;
    wire           last = (count_reg == ONE); // Final cycle of the pulse.

    // Next value: abort wins, then the running count, then a new start.
    always_comb begin
        count_next = count_reg;
        done_next  = 1'b0;
        if (abort) begin
            count_next = '0;
        end else if (count_reg != '0) begin
            count_next = count_reg - ONE;
            done_next  = last;
        end else if (start) begin
            count_next = LOAD;
        end
    end

    // Short state update, frozen by the clock enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else if (ce) begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end

    assign busy = (count_reg != '0);
    assign done = done_reg;

endmodule : pulse_timer

// ==== verilog/monitor_config_and_interrupts.sv ====
// Contract
// RULE1: Start bit one runs monitoring, zero stands by.
// RULE2: Clearing start leaves asserted interrupt outputs asserted.
// RULE3: Management interrupt needs configuration bit 1.
// RULE4: Host interrupt needs configuration bit 2.
// RULE5: Bit 3 drops outputs, halts monitoring, keeps status.
// RULE6: Bit 4 gives 20 ms reset pulse if enabled.
// RULE7: Bit 5 picks non-maskable or request flavour.
// RULE8: Bit 6 drives bypass pin low.
// RULE9: Bit 7 restores defaults, then reads zero.
// RULE10: Configuration powers up as 08h.
// RULE11: Status and management masks power up 00h; status read-only.
// RULE12: Limit crossings set voltage and temperature bits.
// RULE13: Board thermal event sets first status bit 5.
// RULE14: Fan limit sets status bits for three fans.
// RULE15: Chassis intrusion rising sets second status bit 4.
// RULE16: 32nd storage write sets second status bit 5.
// RULE17: External input falling sets bit 6; bit 7 reserved.
// RULE18: Management mask bit blocks matching status bit.
// RULE19: Host masks at 45h, 46h; external event masked.
// RULE20: Outputs assert on enable, no clearing, unmasked event.
// RULE21: Status bits hold until read, read clears.
module monitor_config_and_interrupts
    import mon_pkg::*;
#(
    parameter int RESET_PULSE_LEN = mon_pkg::RESET_PULSE_CYCLES // Reset pulse cycles.
) (
    input  wire logic       clk,                        // Core clock, 50 MHz.
    input  wire logic       rst_n,                      // Power-on reset, active low.
    input  wire logic       ce,                         // Clock enable, freezes all state.
    input  wire logic [7:0] reg_addr,                   // Register offset.
    input  wire logic       reg_wr,                     // Write strobe, one cycle.
    input  wire logic [7:0] reg_wdata,                  // Write data.
    input  wire logic       reg_rd,                     // Read strobe, one cycle.
    output logic      [7:0] reg_rdata,                  // Read data, registered.
    output logic            reg_rvalid,                 // Read data valid pulse.
    input  wire logic [6:0] voltage_limit_event,        // Inputs a..e, negative a, b.
    input  wire logic       temp_limit_event,           // Temperature limit crossed.
    input  wire logic [2:0] tach_limit_event,           // Fan one, two, three over limit.
    input  wire logic       board_thermal_event_n,      // Board thermal input, low active.
    input  wire logic       chassis_intrusion,          // Chassis intrusion, high active.
    input  wire logic       external_mgmt_irq_input_n,  // Chained interrupt input.
    input  wire logic       post_write,                 // Storage buffer write pulse.
    input  wire logic [4:0] post_write_addr,            // Location being written.
    output logic            monitor_active,             // Monitoring is running.
    output logic            system_mgmt_irq_n,          // Management interrupt, low.
    output logic            host_nmi_n,                 // Non-maskable flavour, low.
    output logic            host_irq_n,                 // Request flavour, low.
    output logic            reset_out_n,                // Reset pulse pin, low.
    output logic            power_bypass_n              // Bypass pin, low active.
);

    // ------------------------------------------------------------------
    // Helper function.
    // ------------------------------------------------------------------

    // True when any status bit is set whose mask bit is zero.
    function automatic logic unmasked_pending(input logic [7:0] status,
                                              input logic [7:0] mask);
        unmasked_pending = |(status & ~mask);
    endfunction : unmasked_pending

    // ------------------------------------------------------------------
    // State declarations.
    // ------------------------------------------------------------------

    typedef enum logic [0:0] {
        PULSE_IDLE,   // No reset pulse in flight.
        PULSE_ACTIVE  // Timer is driving the reset pin.
    } pulse_state_t;

    logic [7:0]   config_reg;        // Monitor configuration.
    logic [7:0]   config_next;
    logic [7:0]   status1_reg;       // First event status.
    logic [7:0]   status1_next;
    logic [7:0]   status2_reg;       // Second event status.
    logic [7:0]   status2_next;
    logic [7:0]   mmask1_reg;        // First management mask.
    logic [7:0]   mmask2_reg;        // Second management mask.
    logic [7:0]   hmask1_reg;        // First host mask.
    logic [7:0]   hmask2_reg;        // Second host mask.
    pulse_state_t pulse_state_reg;   // Reset pulse sequencer.
    pulse_state_t pulse_state_next;
    logic         bti_prev_reg;      // Last board thermal level.
    logic         chassis_prev_reg;  // Last chassis intrusion level.
    logic         ext_prev_reg;      // Last external input level.
    logic [7:0]   rdata_reg;         // Read answer.
    logic         rvalid_reg;        // Read answer valid.
    logic         active_reg;        // Registered monitoring flag.
    logic         mgmt_n_reg;        // Registered management output.
    logic         nmi_n_reg;         // Registered non-maskable output.
    logic         irq_n_reg;         // Registered request output.
    logic         reset_n_reg;       // Registered reset pin.
    logic         bypass_n_reg;      // Registered bypass pin.
    logic         timer_busy;        // Reset timer running.
    logic         timer_done;        // Reset timer finished.

    // ------------------------------------------------------------------
    // Register port decode.
    // ------------------------------------------------------------------

    wire wr_cfg    = reg_wr && (reg_addr == ADDR_CONFIG);
    wire wr_mmask1 = reg_wr && (reg_addr == ADDR_MMASK1);
    wire wr_mmask2 = reg_wr && (reg_addr == ADDR_MMASK2);
    wire wr_hmask1 = reg_wr && (reg_addr == ADDR_HMASK1);
    wire wr_hmask2 = reg_wr && (reg_addr == ADDR_HMASK2);
    wire rd_stat1  = reg_rd && (reg_addr == ADDR_STATUS1);
    wire rd_stat2  = reg_rd && (reg_addr == ADDR_STATUS2);

    // A write with the restore bit acts as a soft reset of the configuration, status and mask
    // registers and the pulse sequencer; the serial bus address lives elsewhere and is untouched.
    wire restore = wr_cfg && reg_wdata[CFG_RESTORE]; // [RULE9]

    // Read multiplexer; unmapped offsets answer zero.
    wire [7:0] rd_mux =
        (reg_addr == ADDR_CONFIG)  ? config_reg  :
        (reg_addr == ADDR_STATUS1) ? status1_reg :
        (reg_addr == ADDR_STATUS2) ? status2_reg :
        (reg_addr == ADDR_MMASK1)  ? mmask1_reg  :
        (reg_addr == ADDR_MMASK2)  ? mmask2_reg  :
        (reg_addr == ADDR_HMASK1)  ? hmask1_reg  :
        (reg_addr == ADDR_HMASK2)  ? hmask2_reg  : READ_UNMAPPED;

    // ------------------------------------------------------------------
    // Monitoring and event capture.
    // ------------------------------------------------------------------

    // Comparator results only count while monitoring runs; clearing the
    // interrupt bit halts monitoring as well as the start bit does.
    wire monitor_on = config_reg[CFG_START] && !config_reg[CFG_INT_CLEAR]; // [RULE1] [RULE5]

    wire [6:0] volt_set = voltage_limit_event & {7{monitor_on}}; // [RULE12]
    wire       temp_set = temp_limit_event && monitor_on;        // [RULE12]
    wire [2:0] tach_set = tach_limit_event & {3{monitor_on}};    // [RULE14]

    // The three pin events are edge detected so a held level latches once; the storage write is taken as a level.
    wire bti_set     = bti_prev_reg && !board_thermal_event_n;           // [RULE13]
    wire chassis_set = !chassis_prev_reg && chassis_intrusion;           // [RULE15]
    wire post_set    = post_write && (post_write_addr == POST_LAST_ADDR); // [RULE16]
    wire ext_set     = ext_prev_reg && !external_mgmt_irq_input_n;       // [RULE17]

    // Bit layout of the two status registers; bit 7 of the second is
    // reserved and can never set.
    wire [7:0] set1 = {tach_set[1:0], bti_set, temp_set, volt_set[3:0]};     // [RULE12] [RULE14]
    wire [7:0] set2 = {1'b0, ext_set, post_set, chassis_set, tach_set[2],
                       volt_set[6:4]};                                    // [RULE17]

    // Status holds until read; a new event in the read cycle survives,
    // so the set term wins over the read clear.
    always_comb begin
        status1_next = status1_reg;
        status2_next = status2_reg;
        if (restore) begin
            status1_next = STATUS_RESET; // [RULE9]
            status2_next = STATUS_RESET;
        end else begin
            status1_next = (rd_stat1 ? STATUS_RESET : status1_reg) | set1; // [RULE21]
            status2_next = (rd_stat2 ? STATUS_RESET : status2_reg) | set2; // [RULE21]
        end
    end

    // ------------------------------------------------------------------
    // Reset pulse sequencing.
    // ------------------------------------------------------------------

    wire reset_en    = mmask2_reg[MMASK2_RESET_EN];
    wire pulse_req   = config_reg[CFG_RESET_PULSE];
    wire pulse_start = (pulse_state_reg == PULSE_IDLE) && pulse_req && reset_en; // [RULE6]

    // A request without the enable would otherwise stick forever, so it
    // is dropped at once; a finished pulse also clears the request.
    wire pulse_clear = timer_done ||
                       ((pulse_state_reg == PULSE_IDLE) && pulse_req && !reset_en); // [RULE6]

    // Sequencer: idle until a permitted request, active until done.
    always_comb begin
        pulse_state_next = pulse_state_reg;
        case (pulse_state_reg)
            PULSE_IDLE: begin
                if (pulse_start) begin
                    pulse_state_next = PULSE_ACTIVE;
                end
            end
            PULSE_ACTIVE: begin
                if (timer_done) begin
                    pulse_state_next = PULSE_IDLE;
                end
            end
            default: begin
                pulse_state_next = PULSE_IDLE;
            end
        endcase
        if (restore) begin
            pulse_state_next = PULSE_IDLE;
        end
    end

    // Long timer; the length is a parameter so a bench can shorten it.
    pulse_timer #(
        .CYCLES (RESET_PULSE_LEN)
    ) u_reset_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .start (pulse_start),
        .abort (restore),
        .busy  (timer_busy),
        .done  (timer_done)
    );

    // ------------------------------------------------------------------
    // Configuration next value.
    // ------------------------------------------------------------------

    // The pulse bit is owned by hardware once set: a host write of zero
    // cannot cut a pulse short, and a write of one wins over a clear.
    always_comb begin
        config_next = config_reg;
        if (restore) begin
            config_next = CONFIG_RESET; // [RULE9]
        end else begin
            if (wr_cfg) begin
                config_next = reg_wdata;
            end
            config_next[CFG_RESET_PULSE] = (pulse_req && !pulse_clear) ||
                                           (wr_cfg && reg_wdata[CFG_RESET_PULSE]); // [RULE6]
            config_next[CFG_RESTORE] = 1'b0; // [RULE9]
        end
    end

    // ------------------------------------------------------------------
    // Interrupt output terms.
    // ------------------------------------------------------------------

    // The start bit takes no part here, so stopping monitoring leaves an
    // asserted output asserted until status is read or clearing is set.
    wire int_clear  = config_reg[CFG_INT_CLEAR]; // [RULE2]
    wire mgmt_cond  = config_reg[CFG_MGMT_EN] && !int_clear &&
                      (unmasked_pending(status1_reg, mmask1_reg) ||
                       unmasked_pending(status2_reg, mmask2_reg)); // [RULE3] [RULE18] [RULE20]
    wire host_cond  = config_reg[CFG_HOST_EN] && !int_clear &&
                      (unmasked_pending(status1_reg, hmask1_reg) ||
                       unmasked_pending(status2_reg, hmask2_reg)); // [RULE4] [RULE19] [RULE20]
    wire nmi_select = config_reg[CFG_NMI_SEL];

    // ------------------------------------------------------------------
    // Register state.
    // ------------------------------------------------------------------

    // Configuration and status; defaults match the power-on values.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            config_reg  <= CONFIG_RESET; // [RULE10]
            status1_reg <= STATUS_RESET; // [RULE11]
            status2_reg <= STATUS_RESET; // [RULE11]
        end else if (ce) begin
            config_reg  <= config_next;
            status1_reg <= status1_next;
            status2_reg <= status2_next;
        end
    end

    // Mask registers; restore returns them to their defaults.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mmask1_reg <= MMASK_RESET;  // [RULE11]
            mmask2_reg <= MMASK_RESET;  // [RULE11]
            hmask1_reg <= HMASK1_RESET; // [RULE19]
            hmask2_reg <= HMASK2_RESET; // [RULE19]
        end else if (ce) begin
            mmask1_reg <= restore ? MMASK_RESET  : (wr_mmask1 ? reg_wdata : mmask1_reg);
            mmask2_reg <= restore ? MMASK_RESET  : (wr_mmask2 ? reg_wdata : mmask2_reg);
            hmask1_reg <= restore ? HMASK1_RESET : (wr_hmask1 ? reg_wdata : hmask1_reg);
            hmask2_reg <= restore ? HMASK2_RESET : (wr_hmask2 ? reg_wdata : hmask2_reg);
        end
    end

    // Pin history for edge detection, reset to the idle levels.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bti_prev_reg     <= 1'b1;
            chassis_prev_reg <= 1'b0;
            ext_prev_reg     <= 1'b1;
        end else if (ce) begin
            bti_prev_reg     <= board_thermal_event_n;
            chassis_prev_reg <= chassis_intrusion;
            ext_prev_reg     <= external_mgmt_irq_input_n;
        end
    end

    // Reset pulse sequencer state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pulse_state_reg <= PULSE_IDLE;
        end else if (ce) begin
            pulse_state_reg <= pulse_state_next;
        end
    end

    // Read answer, one cycle after the strobe.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg  <= READ_UNMAPPED;
            rvalid_reg <= 1'b0;
        end else if (ce) begin
            rdata_reg  <= reg_rd ? rd_mux : rdata_reg;
            rvalid_reg <= reg_rd;
        end
    end

    // Pin outputs; each one leaves a flip-flop, costing one cycle of lag.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            active_reg   <= 1'b0;
            mgmt_n_reg   <= 1'b1;
            nmi_n_reg    <= 1'b1;
            irq_n_reg    <= 1'b1;
            reset_n_reg  <= 1'b1;
            bypass_n_reg <= 1'b1;
        end else if (ce) begin
            active_reg   <= monitor_on;                   // [RULE1]
            mgmt_n_reg   <= !mgmt_cond;                   // [RULE20]
            nmi_n_reg    <= !(host_cond && nmi_select);   // [RULE7]
            irq_n_reg    <= !(host_cond && !nmi_select);  // [RULE7]
            reset_n_reg  <= !timer_busy;                  // [RULE6]
            bypass_n_reg <= !config_reg[CFG_BYPASS];      // [RULE8]
        end
    end

    // ------------------------------------------------------------------
    // Output connections.
    // ------------------------------------------------------------------

    assign reg_rdata         = rdata_reg;
    assign reg_rvalid        = rvalid_reg;
    assign monitor_active    = active_reg;
    assign system_mgmt_irq_n = mgmt_n_reg;
    assign host_nmi_n        = nmi_n_reg;
    assign host_irq_n        = irq_n_reg;
    assign reset_out_n       = reset_n_reg;
    assign power_bypass_n    = bypass_n_reg;

endmodule : monitor_config_and_interrupts

// ==== dv/mon_chk.sv ====
module mon_chk #(parameter int RESET_PULSE_LEN = 10) (
    input wire logic       clk, rst_n, ce, reg_wr,               // Clock, reset, strobes.
    input wire logic [7:0] reg_addr, reg_wdata,                  // Register port.
    input wire logic       monitor_active, system_mgmt_irq_n,    // Status outputs.
    input wire logic       host_nmi_n, host_irq_n, reset_out_n,  // Interrupt and reset pins.
    input wire logic       power_bypass_n                        // Bypass pin.
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire cw = ce && reg_wr && reg_addr == 8'h40; // Configuration write taken.
    int  low_cnt;                                // Cycles the reset pin has been low.
    // Counting in helper logic keeps long pulses off the repetition operator.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) low_cnt <= 0;
        else low_cnt <= reset_out_n ? 0 : low_cnt + 1;
    end
    a_start_runs: assert property (cw && !reg_wdata[7] |=> ##1
        monitor_active == ($past(reg_wdata[0], 2) && !$past(reg_wdata[3], 2)))
        else $error("monitor state wrong");
    a_mgmt_gate: assert property (cw && !reg_wdata[1] |=> ##1 system_mgmt_irq_n)
        else $error("management irq without enable");
    a_host_gate: assert property (cw && !reg_wdata[2] |=> ##1 host_irq_n && host_nmi_n)
        else $error("host irq without enable");
    a_clear_drops: assert property (cw && reg_wdata[3] |=> ##1 system_mgmt_irq_n
        && host_irq_n && host_nmi_n && !monitor_active) else $error("clear ignored");
    // A restore write may cut a pulse short, so those pulses are left out.
    a_pulse_len: assert property ($rose(reset_out_n) && !$past(cw) && !$past(cw, 2)
        |-> low_cnt == RESET_PULSE_LEN) else $error("reset pulse length wrong");
    a_one_flavour: assert property (host_nmi_n || host_irq_n)
        else $error("both host flavours low");
    a_bypass_pin: assert property (cw && !reg_wdata[7] |=> ##1
        power_bypass_n == !$past(reg_wdata[6], 2)) else $error("bypass pin wrong");
    a_restore_all: assert property (cw && reg_wdata[7] |=> ##1 power_bypass_n
        && system_mgmt_irq_n && !monitor_active) else $error("restore incomplete");
    a_reset_idle: assert property ($rose(rst_n) |-> system_mgmt_irq_n && host_irq_n
        && host_nmi_n && reset_out_n && !monitor_active) else $error("bad reset state");
    c_mgmt: cover property (!system_mgmt_irq_n);
    c_nmi: cover property (!host_nmi_n);
    c_pulse: cover property ($rose(reset_out_n));
endmodule : mon_chk
bind monitor_config_and_interrupts mon_chk #(.RESET_PULSE_LEN(RESET_PULSE_LEN)) chk (.*);

// ==== dv/host_model.sv ====
module host_model (
    input  wire logic clk,         // Core clock.
    input  wire logic reset_out_n, // Reset pin from the block.
    output int        resets_seen  // Resets taken by the chipset.
);
    timeunit 1ns;
    timeprecision 1ns;
    initial resets_seen = 0;
    // Falls are counted: the power-up rise out of X is no reset.
    always @(negedge reset_out_n) resets_seen++;
endmodule : host_model

// ==== dv/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, tmp = 0, bte_n = 1, chas = 0, ext_n = 1, pw = 0;
    logic [7:0] addr = 0, wd = 0, rdata;
    logic [6:0] volt = 0;
    logic [2:0] tach = 0;
    logic rv, act, mgi_n, hnmi_n, hirq_n, rst_o_n, byp_n;
    int error_cnt = 0, n_compared = 0, resets, n;
    wire [7:0] outs = {5'h0, mgi_n, hirq_n, hnmi_n}; // Interrupt pins for comparison.
    monitor_config_and_interrupts #(.RESET_PULSE_LEN(10)) uut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
        .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv), .voltage_limit_event(volt),
        .temp_limit_event(tmp), .tach_limit_event(tach), .board_thermal_event_n(bte_n),
        .chassis_intrusion(chas), .external_mgmt_irq_input_n(ext_n), .post_write(pw),
        .post_write_addr(volt[4:0]), .monitor_active(act), .system_mgmt_irq_n(mgi_n),
        .host_nmi_n(hnmi_n), .host_irq_n(hirq_n), .reset_out_n(rst_o_n), .power_bypass_n(byp_n));
    host_model host (.clk(clk), .reset_out_n(rst_o_n), .resets_seen(resets));
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr8(input logic [7:0] a, d);
        @(negedge clk) {addr, wd, wr} = {a, d, 1'b1};
        @(negedge clk) wr = 0;
    endtask : wr8
    task automatic rd8(input logic [7:0] a, exp);
        @(negedge clk) {addr, rd} = {a, 1'b1};
        @(negedge clk) rd = 0;
        chk(rdata, exp);
        chk({7'h0, rv}, 8'h01);
    endtask : rd8
    task automatic t_defaults;
        logic [7:0] e [8] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00};
        for (int i = 0; i < 8; i++) rd8(8'h40 + 8'(i), e[i]);
        $display("defaults test done");
    endtask : t_defaults
    task automatic t_events;
        wr8(8'h40, 8'h07);
        @(negedge clk) {volt, tmp, tach, bte_n, chas, ext_n, pw} = 15'h7ff5;
        @(negedge clk) {volt, tmp, tach, pw} = 0;
        repeat (2) @(negedge clk);
        chk(outs, 8'h01);
        wr8(8'h41, 8'h00);
        rd8(8'h41, 8'hff);
        rd8(8'h42, 8'h7f);
        rd8(8'h41, 8'h00);
        rd8(8'h42, 8'h00);
        {bte_n, chas, ext_n} = 3'b101;
        repeat (2) @(negedge clk);
        chk(outs, 8'h07);
        $display("events test done");
    endtask : t_events
    task automatic t_masks;
        wr8(8'h43, 8'hff);
        wr8(8'h44, 8'h7f);
        wr8(8'h40, 8'h27);
        for (int i = 0; i < 2; i++) begin
            @(negedge clk) tmp = 1;
            @(negedge clk) tmp = 0;
            repeat (2) @(negedge clk);
            chk(outs, 8'h06);
            wr8(8'h40, 8'h26);
        end
        wr8(8'h40, 8'h2e);
        repeat (2) @(negedge clk);
        chk(outs, 8'h07);
        rd8(8'h41, 8'h10);
        @(negedge clk) {tmp, pw} = '1;
        @(negedge clk) {tmp, pw} = '0;
        rd8(8'h41, 8'h00);
        rd8(8'h42, 8'h00);
        $display("masks test done");
    endtask : t_masks
    task automatic t_pulse;
        wr8(8'h44, 8'h80);
        wr8(8'h40, 8'h50);
        for (n = 0; n < 50 && rst_o_n; n++) @(negedge clk);
        if (rst_o_n) begin
            error_cnt++;
            wrap_up();
        end
        for (n = 0; n < 50 && !rst_o_n; n++) @(negedge clk);
        chk(n[7:0], 8'h0a);
        chk(8'(resets), 8'h01);
        chk(8'(byp_n), 8'h00);
        rd8(8'h40, 8'h40);
        wr8(8'h40, 8'h80);
        rd8(8'h40, 8'h08);
        rd8(8'h44, 8'h00);
        $display("pulse test done");
    endtask : t_pulse
    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (3) @(negedge clk);
        rst_n = 1;
        t_defaults();
        t_events();
        t_masks();
        t_pulse();
        wrap_up();
    end
endmodule : tb_top
